// File: rtl/switch_matrix_defines.svh
`ifndef SWITCH_MATRIX_DEFINES_SVH
`define SWITCH_MATRIX_DEFINES_SVH
`define OP_CONNECT 4'h1
`define OP_DISCONNECT 4'h2
`define OP_INSERT 4'h4
`define OP_SAMPLE 4'hB
`define OP_CONTROL 4'h8
`define OP_MASK 4'hE
`define READBACK_RESET 8'hFF
`define CM_IDLE_WORD 9'h1FF
`define ATTN_PULSE_CYCLES 2'h2
`define LABEL_SKIP 2'h1
`define CH0_SLOT 5'h00
`define INIT_LAST 8'hFF
`endif

// File: rtl/switch_matrix_pkg.sv
`default_nettype none
package switch_matrix_pkg;
  typedef struct packed {
    logic cs_n;
    logic wr_n;
    logic rd_n;
    logic cmd;
    logic frame_sync_n;
    logic match;
    logic [7:0] data;
  } host_pins_t;
  typedef struct packed {
    logic src_sel;
    logic [7:0] word;
  } cm_word_t;
  typedef struct packed {
    logic [2:0] bus;
    logic src_sel;
    logic [3:0] opcode;
  } rb2_t;
  typedef enum logic [2:0] {
    X_IDLE = 3'b001,
    X_ANNOUNCE = 3'b010,
    X_STREAM = 3'b100
  } extract_state_t;
endpackage : switch_matrix_pkg
`default_nettype wire

// File: rtl/switch_matrix_instruction_port.sv
`include "switch_matrix_defines.svh"
`default_nettype none
module switch_matrix_instruction_port (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic cs_n,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic cmd_data_select,
  input wire logic frame_sync_n,
  input wire logic match,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe_n,
  output logic attention_pin,
  input wire logic sm_wr_en,
  input wire logic [7:0] sm_wr_addr,
  input wire logic [7:0] sm_wr_data
);
  switch_matrix_pkg::host_pins_t pins_raw;
  switch_matrix_pkg::host_pins_t sync1;
  switch_matrix_pkg::host_pins_t p;
  switch_matrix_pkg::host_pins_t p_prev;
  logic [7:0] speech_store [256];
  switch_matrix_pkg::cm_word_t connection_store [256];
  logic [4:0] stack [4];
  logic [4:0] next_stack [4];
  logic [3:0] op, next_op;
  logic pending, next_pending;
  logic invalid_flag, next_invalid_flag;
  logic short_unread, next_short_unread;
  logic frame_req, next_frame_req;
  logic extract_en, next_extract_en;
  logic [7:0] mask, next_mask;
  logic [7:0] background, next_background;
  logic [7:0] rb1, next_rb1;
  switch_matrix_pkg::rb2_t rb2, next_rb2;
  switch_matrix_pkg::extract_state_t state, next_state;
  logic [1:0] pulse_cnt, next_pulse_cnt;
  logic init_busy, next_init_busy;
  logic [7:0] init_cnt, next_init_cnt;
  logic next_attention_pin, next_data_oe_n;
  logic [7:0] next_data_out;
  logic cm_we;
  logic [7:0] cm_waddr;
  switch_matrix_pkg::cm_word_t cm_wdata;
  logic data_write, op_write, rd_rise1, rd_rise2, frame_start, exec_go, op_valid;
  logic [7:0] out_addr, relevant;
  switch_matrix_pkg::cm_word_t cm_sel;

  function automatic logic [2:0] ones_count(input logic [7:0] v);
    logic [2:0] c;
    c = 3'h0;
    for (int i = 0; i < 8; i++) begin
      c = c + {2'b00, v[i]};
    end
    return c;
  endfunction : ones_count

  function automatic logic [2:0] top_index(input logic [7:0] v);
    logic [2:0] t;
    t = 3'h0;
    for (int i = 0; i < 8; i++) begin
      if (v[i]) begin
        t = 3'(i);
      end
    end
    return t;
  endfunction : top_index

  function automatic logic opcode_ok(input logic [3:0] o);
    return (o == `OP_CONNECT) || (o == `OP_DISCONNECT) || (o == `OP_INSERT) ||
           (o == `OP_SAMPLE) || (o == `OP_CONTROL) || (o == `OP_MASK);
  endfunction : opcode_ok

  assign pins_raw = '{cs_n: cs_n, wr_n: wr_n, rd_n: rd_n, cmd: cmd_data_select,
                      frame_sync_n: frame_sync_n, match: match, data: data_in};

  // Two-flop synchroniser, then one more stage for edge detection
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1 <= '{cs_n: 1'b1, wr_n: 1'b1, rd_n: 1'b1, cmd: 1'b0, frame_sync_n: 1'b1, match: 1'b0, data: 8'h00};
      p <= '{cs_n: 1'b1, wr_n: 1'b1, rd_n: 1'b1, cmd: 1'b0, frame_sync_n: 1'b1, match: 1'b0, data: 8'h00};
      p_prev <= '{cs_n: 1'b1, wr_n: 1'b1, rd_n: 1'b1, cmd: 1'b0, frame_sync_n: 1'b1, match: 1'b0, data: 8'h00};
    end else begin
      sync1 <= pins_raw;
      p <= sync1;
      p_prev <= p;
    end
  end

  // Writes and reads are taken at the rising edge of their strobe
  assign data_write = !p_prev.cs_n && !p_prev.wr_n && p.wr_n && !p_prev.cmd;
  assign op_write = !p_prev.cs_n && !p_prev.wr_n && p.wr_n && p_prev.cmd;
  assign rd_rise1 = !p_prev.cs_n && !p_prev.rd_n && p.rd_n && !p_prev.cmd;
  assign rd_rise2 = !p_prev.cs_n && !p_prev.rd_n && p.rd_n && p_prev.cmd;
  assign frame_start = p_prev.frame_sync_n && !p.frame_sync_n;
  assign op_valid = opcode_ok(p_prev.data[3:0]);
  assign exec_go = pending && !init_busy;
  assign out_addr = {stack[2][2:0], stack[3]};
  assign cm_sel = connection_store[out_addr];

  always_comb begin
    relevant = 8'h00;
    for (int b = 0; b < 8; b++) begin
      relevant[b] = speech_store[{3'(b), `CH0_SLOT}][7:6] != `LABEL_SKIP;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sm_wr_en) begin
      speech_store[sm_wr_addr] <= sm_wr_data;
    end
    if (cm_we) begin
      connection_store[cm_waddr] <= cm_wdata;
    end
  end

  always_comb begin
    logic [7:0] rest;
    logic [2:0] b;
    rest = 8'h00;
    b = 3'h0;
    next_stack = stack;
    next_op = op;
    next_pending = pending;
    next_invalid_flag = invalid_flag;
    next_short_unread = short_unread;
    next_frame_req = frame_req;
    next_extract_en = extract_en;
    next_mask = mask;
    next_background = background;
    next_rb1 = rb1;
    next_rb2 = rb2;
    next_state = state;
    next_pulse_cnt = (pulse_cnt != 2'h0) ? pulse_cnt - 2'h1 : 2'h0;
    next_init_busy = init_busy;
    next_init_cnt = init_cnt;
    cm_we = 1'b0;
    cm_waddr = out_addr;
    cm_wdata = cm_sel;
    if (init_busy) begin
      cm_we = 1'b1;
      cm_waddr = init_cnt;
      cm_wdata = `CM_IDLE_WORD;
      next_init_cnt = init_cnt + 8'h01;
      next_init_busy = init_cnt != `INIT_LAST;
    end
    if (data_write) begin
      next_stack[0] = stack[1];
      next_stack[1] = stack[2];
      next_stack[2] = stack[3];
      next_stack[3] = p_prev.data[4:0];
    end
    if (op_write) begin
      if (op_valid) begin
        next_op = p_prev.data[3:0];
        next_pending = 1'b1;
        next_invalid_flag = 1'b0;
      end else begin
        next_invalid_flag = 1'b1;
      end
    end
    if (rd_rise2) begin
      next_short_unread = 1'b0;
    end
    if (frame_start && extract_en) begin
      next_frame_req = 1'b1;
      next_mask = background;
      next_state = switch_matrix_pkg::X_IDLE;
    end
    if (exec_go) begin
      next_pending = op_write && op_valid;
      next_short_unread = short_unread || (op != `OP_MASK);
      next_rb2 = '{bus: stack[2][2:0], src_sel: 1'b1, opcode: op};
      case (op)
        `OP_CONNECT, `OP_INSERT: begin
          cm_we = 1'b1;
          if (!p.match) begin
            cm_wdata = `CM_IDLE_WORD;
          end else if (op == `OP_CONNECT) begin
            cm_wdata = {1'b0, stack[0][2:0], stack[1]};
          end else begin
            cm_wdata = {1'b1, stack[0][2:0], stack[1]};
          end
          next_rb1 = cm_wdata.word;
          next_rb2.src_sel = cm_wdata.src_sel;
        end
        `OP_DISCONNECT: begin
          if (p.match) begin
            cm_we = 1'b1;
            cm_wdata = `CM_IDLE_WORD;
            next_rb1 = `READBACK_RESET;
          end else begin
            next_rb2 = rb2;
          end
        end
        `OP_SAMPLE: begin
          if (p.match) begin
            next_rb1 = cm_sel.src_sel ? cm_sel.word : speech_store[cm_sel.word];
            next_rb2.src_sel = cm_sel.src_sel;
          end else begin
            next_rb2 = rb2;
          end
        end
        `OP_CONTROL: begin
          next_rb1 = cm_sel.word;
          next_rb2.src_sel = cm_sel.src_sel;
        end
        default: begin
          if (p.match) begin
            next_mask = {stack[2][2:0], stack[3]};
            next_background = next_mask;
            next_extract_en = next_mask != 8'h00;
            next_frame_req = frame_start && next_extract_en;
            next_state = switch_matrix_pkg::X_IDLE;
            next_rb2 = '{bus: ones_count(next_mask), src_sel: next_mask != 8'h00, opcode: op};
          end else begin
            next_rb2 = rb2;
          end
        end
      endcase
    end else if (frame_req && !short_unread && !pending && !init_busy) begin
      next_frame_req = 1'b0;
      next_mask = mask & relevant;
      if (next_mask != 8'h00) begin
        next_state = switch_matrix_pkg::X_ANNOUNCE;
        next_pulse_cnt = `ATTN_PULSE_CYCLES;
        next_rb2 = '{bus: ones_count(next_mask), src_sel: 1'b1, opcode: `OP_MASK};
      end
    end else if (rd_rise2 && state != switch_matrix_pkg::X_IDLE && !frame_start) begin
      if (mask == 8'h00) begin
        next_state = switch_matrix_pkg::X_IDLE;
      end else begin
        b = top_index(mask);
        rest = mask;
        rest[b] = 1'b0;
        next_mask = rest;
        next_state = switch_matrix_pkg::X_STREAM;
        next_rb1 = speech_store[{b, `CH0_SLOT}];
        next_rb2 = '{bus: b, src_sel: rest != 8'h00, opcode: `OP_MASK};
      end
    end
    next_attention_pin = !(next_invalid_flag || (next_pulse_cnt != 2'h0));
    next_data_out = p.cmd ? rb2 : rb1;
    next_data_oe_n = !(!p.cs_n && !p.rd_n);
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 4; i++) begin
        stack[i] <= 5'h1F;
      end
      op <= 4'hF;
      pending <= 1'b0;
      invalid_flag <= 1'b0;
      short_unread <= 1'b0;
      frame_req <= 1'b0;
      extract_en <= 1'b0;
      mask <= 8'h00;
      background <= 8'h00;
      rb1 <= `READBACK_RESET;
      rb2 <= `READBACK_RESET;
      state <= switch_matrix_pkg::X_IDLE;
      pulse_cnt <= 2'h0;
      init_busy <= 1'b1;
      init_cnt <= 8'h00;
      attention_pin <= 1'b1;
      data_out <= 8'h00;
      data_oe_n <= 1'b1;
    end else begin
      stack <= next_stack;
      op <= next_op;
      pending <= next_pending;
      invalid_flag <= next_invalid_flag;
      short_unread <= next_short_unread;
      frame_req <= next_frame_req;
      extract_en <= next_extract_en;
      mask <= next_mask;
      background <= next_background;
      rb1 <= next_rb1;
      rb2 <= next_rb2;
      state <= next_state;
      pulse_cnt <= next_pulse_cnt;
      init_busy <= next_init_busy;
      init_cnt <= next_init_cnt;
      attention_pin <= next_attention_pin;
      data_out <= next_data_out;
      data_oe_n <= next_data_oe_n;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  a_attn_two_low: assert property (
    (state == switch_matrix_pkg::X_ANNOUNCE && $past(state) != switch_matrix_pkg::X_ANNOUNCE && !invalid_flag
     && pulse_cnt == 2'h2) |-> !attention_pin ##1 !attention_pin ##1 (attention_pin || invalid_flag))
    else $error("attention pulse not two cycles");
  a_announce_flag: assert property (
    $rose(state == switch_matrix_pkg::X_ANNOUNCE) |-> rb2.src_sel && rb2.opcode == `OP_MASK && $stable(rb1))
    else $error("announce readback wrong");
  a_scan_desc: assert property (
    (state == switch_matrix_pkg::X_STREAM && $past(state) == switch_matrix_pkg::X_STREAM && rb2 != $past(rb2)
     && $past(rb2.opcode) == `OP_MASK)
    |-> rb2.bus < $past(rb2.bus))
    else $error("extraction not descending");
  a_invalid_hold: assert property (invalid_flag |-> !attention_pin)
    else $error("attention high on invalid opcode");
  a_invalid_keep: assert property (
    (op_write && !op_valid && !pending && !rd_rise2) |=> $stable(rb1) && $stable(op))
    else $error("invalid opcode changed state");
  a_disc_ones: assert property (
    (exec_go && op == `OP_DISCONNECT && p.match) |=> rb1 == 8'hFF && rb2.src_sel)
    else $error("disconnect readback wrong");
  a_connect_miss: assert property (
    (exec_go && op == `OP_CONNECT && !p.match) |=> rb1 == 8'hFF && rb2.src_sel && rb2.opcode == `OP_CONNECT)
    else $error("unmatched connect not disconnect");
  a_mask_keep_rb1: assert property ((exec_go && op == `OP_MASK) |=> $stable(rb1))
    else $error("mask store changed readback_one");
  a_zero_mask_off: assert property (
    (exec_go && op == `OP_MASK && p.match && stack[2][2:0] == 3'h0 && stack[3] == 5'h00)
    |=> !extract_en && background == 8'h00 && !rb2.src_sel)
    else $error("zero mask did not disable");
  a_read_drive: assert property (
    (!p.cs_n && !p.rd_n) |=> !data_oe_n && data_out == $past(p.cmd ? rb2 : rb1))
    else $error("read data not driven");

  c_announce: cover property ($rose(state == switch_matrix_pkg::X_ANNOUNCE));
  c_stream_end: cover property (state == switch_matrix_pkg::X_STREAM ##1 state == switch_matrix_pkg::X_IDLE);
  c_invalid: cover property ($rose(invalid_flag));
  c_connect: cover property (exec_go && op == `OP_CONNECT && p.match);
  c_rb1_read: cover property (rd_rise1 && state == switch_matrix_pkg::X_STREAM);
endmodule : switch_matrix_instruction_port
`default_nettype wire

// File: tb/host_model.sv
`default_nettype none
module host_model (
  input wire logic ref_clk,
  input wire logic [7:0] data_out,
  input wire logic data_oe_n,
  output var switch_matrix_pkg::host_pins_t pins,
  output logic rd_valid,
  output logic [7:0] rd_data
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    pins = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 8'h00};
    rd_valid = 1'b0;
    rd_data = 8'h00;
  end
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : idle
  // Data held well past the strobe so the input synchronisers see it settled
  task automatic wr(input logic c, input logic [7:0] d);
    @(posedge ref_clk);
    pins.cmd <= c;
    pins.data <= d;
    pins.cs_n <= 1'b0;
    pins.wr_n <= 1'b0;
    idle(6);
    pins.wr_n <= 1'b1;
    idle(6);
    pins.cs_n <= 1'b1;
    pins.data <= ~d;
  endtask : wr
  task automatic rd(input logic c);
    int n;
    @(posedge ref_clk);
    pins.cmd <= c;
    pins.cs_n <= 1'b0;
    pins.rd_n <= 1'b0;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (data_oe_n !== 1'b0 && n < 20);
    rd_data <= data_out;
    rd_valid <= 1'b1;
    pins.rd_n <= 1'b1;
    @(posedge ref_clk);
    rd_valid <= 1'b0;
    idle(6);
    pins.cs_n <= 1'b1;
  endtask : rd
  task automatic set_match(input logic v);
    @(posedge ref_clk);
    pins.match <= v;
  endtask : set_match
  task automatic frame();
    @(posedge ref_clk);
    pins.frame_sync_n <= 1'b0;
    idle(4);
    pins.frame_sync_n <= 1'b1;
  endtask : frame
endmodule : host_model
`default_nettype wire

// File: tb/tb_top.sv
`include "switch_matrix_defines.svh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic sm_wr_en = 1'b0;
  logic [7:0] sm_wr_addr = 8'h00;
  logic [7:0] sm_wr_data = 8'h00;
  logic [7:0] data_out, rd_data, m;
  logic data_oe_n, attention_pin, rd_valid;
  switch_matrix_pkg::host_pins_t pins;
  logic [7:0] exp_q[$];
  logic [7:0] sm_mem[8];
  int err_count = 0;
  int checked = 0;
  integer seed = 32'h2397;
  switch_matrix_instruction_port u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .cs_n(pins.cs_n),
    .wr_n(pins.wr_n), .rd_n(pins.rd_n), .cmd_data_select(pins.cmd), .frame_sync_n(pins.frame_sync_n),
    .match(pins.match), .data_in(data_oe_n ? pins.data : data_out), .data_out(data_out),
    .data_oe_n(data_oe_n), .attention_pin(attention_pin), .sm_wr_en(sm_wr_en), .sm_wr_addr(sm_wr_addr),
    .sm_wr_data(sm_wr_data));
  host_model u_host (.ref_clk(ref_clk), .data_out(data_out), .data_oe_n(data_oe_n), .pins(pins),
    .rd_valid(rd_valid), .rd_data(rd_data));
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %02h expected %02h", $time, got, exp);
    end
  endtask : check
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop
  always @(posedge ref_clk) begin
    if (rd_valid === 1'b1) begin
      check(rd_data, exp_q.pop_front());
    end
  end
  task automatic rd(input logic c, input logic [7:0] e);
    exp_q.push_back(e);
    u_host.rd(c);
  endtask : rd
  // Parameter bytes go out most significant byte first, then the opcode
  task automatic instr(input logic [31:0] b, input int nb, input logic [3:0] op);
    for (int i = nb - 1; i >= 0; i--) begin
      u_host.wr(1'b0, b[i*8+:8]);
    end
    u_host.wr(1'b1, {4'h0, op});
    u_host.idle(8);
  endtask : instr
  task automatic sm_put(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    sm_wr_en <= 1'b1;
    sm_wr_addr <= a;
    sm_wr_data <= d;
    @(posedge ref_clk);
    sm_wr_en <= 1'b0;
  endtask : sm_put
  // One full extraction pass for mask m; prev is readback_one before the pass
  task automatic extract(input logic [7:0] prev);
    int n, k;
    u_host.frame();
    for (k = 0; k < 40 && attention_pin !== 1'b0; k++) @(posedge ref_clk);
    n = 0;
    while (attention_pin === 1'b0 && n < 10) begin
      @(posedge ref_clk);
      n++;
    end
    check(8'(n), 8'h02);
    rd(1'b0, prev);
    rd(1'b1, {3'd3, 1'b1, `OP_MASK});
    k = 3;
    for (int b = 7; b >= 0; b--) begin
      if (m[b] && sm_mem[b][7:6] != 2'b01) begin
        k--;
        rd(1'b0, sm_mem[b]);
        rd(1'b1, {3'(b), k != 0, `OP_MASK});
      end
    end
  endtask : extract
  initial begin
    logic [2:0] ib, ob;
    logic [4:0] is, os;
    logic [7:0] v;
    int n;
    repeat (20) @(posedge ref_clk);
    check({6'h0, attention_pin, data_oe_n}, 8'h03);
    reset_n <= 1'b1;
    repeat (300) @(posedge ref_clk);
    rd(1'b0, `READBACK_RESET);
    rd(1'b1, `READBACK_RESET);
    for (int b = 0; b < 8; b++) begin
      v = 8'($random(seed));
      v[7:6] = (b == 6 || b == 1) ? 2'b01 : {1'b1, v[6]};
      sm_mem[b] = v;
      sm_put({3'(b), `CH0_SLOT}, v);
    end
    ib = 3'($random(seed));
    is = 5'($random(seed)) | 5'h01;
    ob = 3'($random(seed));
    os = 5'($random(seed));
    instr({5'h0, ib, 3'h0, is, 5'h0, ob, 3'h0, os}, 4, `OP_CONNECT);
    rd(1'b0, {ib, is});
    rd(1'b1, {ob, 1'b0, `OP_CONNECT});
    v = 8'($random(seed));
    sm_put({ib, is}, v);
    instr({21'h0, ob, 3'h0, os}, 2, `OP_SAMPLE);
    rd(1'b0, v);
    rd(1'b1, {ob, 1'b0, `OP_SAMPLE});
    u_host.set_match(1'b0);
    instr({21'h0, ob, 3'h0, os}, 2, `OP_CONTROL);
    rd(1'b0, {ib, is});
    rd(1'b1, {ob, 1'b0, `OP_CONTROL});
    instr({21'h0, ob, 3'h0, os}, 2, `OP_DISCONNECT);
    rd(1'b1, {ob, 1'b0, `OP_CONTROL});
    instr({5'h0, ib, 3'h0, is, 5'h0, ob, 3'h0, os}, 4, `OP_CONNECT);
    rd(1'b0, 8'hFF);
    rd(1'b1, {ob, 1'b1, `OP_CONNECT});
    u_host.set_match(1'b1);
    v = 8'($random(seed));
    instr({5'h0, v[7:5], 3'h0, v[4:0], 5'h0, ob, 3'h0, os}, 4, `OP_INSERT);
    rd(1'b0, v);
    rd(1'b1, {ob, 1'b1, `OP_INSERT});
    instr({21'h0, ob, 3'h0, os}, 2, `OP_DISCONNECT);
    rd(1'b0, 8'hFF);
    rd(1'b1, {ob, 1'b1, `OP_DISCONNECT});
    u_host.wr(1'b1, 8'h03);
    u_host.idle(8);
    check({7'h0, attention_pin}, 8'h00);
    rd(1'b0, 8'hFF);
    instr({21'h0, ob, 3'h0, os}, 2, `OP_CONTROL);
    check({7'h0, attention_pin}, 8'h01);
    rd(1'b1, {ob, 1'b1, `OP_CONTROL});
    m = 8'hCB;
    instr({21'h0, m[7:5], 3'h0, m[4:0]}, 2, `OP_MASK);
    rd(1'b1, {3'd5, 1'b1, `OP_MASK});
    extract(8'hFF);
    extract(sm_mem[0]);
    // Mask stored again with readback_two left unread
    instr({21'h0, m[7:5], 3'h0, m[4:0]}, 2, `OP_MASK);
    extract(sm_mem[0]);
    instr(32'h0, 2, `OP_MASK);
    rd(1'b1, {3'd0, 1'b0, `OP_MASK});
    u_host.frame();
    n = 0;
    repeat (30) begin
      @(posedge ref_clk);
      if (attention_pin !== 1'b1) n++;
    end
    check(8'(n), 8'h00);
    u_host.idle(4);
    report_and_stop();
  end
  initial begin
    #(50 * 20000);
    err_count++;
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
